// File: shared/mclk_sel_pkg.sv
// Package: constants and types for the master clock selection block
package mclk_sel_pkg;
   // Register byte offsets
   localparam logic [7:0] CLK_CTRL_OFS  = 8'h00;
   localparam logic [7:0] PORT_MODE_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS    = 8'h08;
   localparam logic [7:0] RATIO_OFS     = 8'h0c;

   // Clock source switch field encodings
   typedef enum logic [1:0] {
      SW_MANUAL_PLL = 2'h0,
      SW_MANUAL_EXT = 2'h1,
      SW_AUTO       = 2'h2,
      SW_AUTO_ALT   = 2'h3
   } clock_source_switch_field_t;

   typedef enum logic [1:0] {
      SPD_SINGLE = 2'h0,
      SPD_DOUBLE = 2'h1,
      SPD_QUAD   = 2'h2
   } speed_t;

   // Clock control register, low bits of word
   typedef struct packed {
      logic                       force_lock_flag;
      logic                       pll_ref_select;
      clock_source_switch_field_t sw;
   } clock_source_switch_ctrl_t;

   // Port mode register, low bits of word
   typedef struct packed {
      logic   one_line_alt;
      logic   one_line;
      logic   aux_slave;
      logic   codec_slave;
      speed_t aux_speed;
      speed_t codec_speed;
   } port_mode_t;

   // Pins sampled from outside the hclk domain
   typedef struct packed {
      logic pll_lock;
      logic ext_master_clock_in;
      logic aux_port_frame_clock;
      logic aux_port_bit_clock;
      logic codec_port_frame_clock;
      logic codec_port_bit_clock;
   } clk_pins_t;

   localparam int unsigned PIN_W = $bits(clk_pins_t);
   localparam clock_source_switch_ctrl_t CTRL_RESET  = '0;
   localparam port_mode_t                MODE_RESET  = '0;

   // Ratios: oversampling, PLL multiple and slave clock ratios
   localparam logic [9:0] R32  = 10'h020;
   localparam logic [9:0] R48  = 10'h030;
   localparam logic [9:0] R64  = 10'h040;
   localparam logic [9:0] R96  = 10'h060;
   localparam logic [9:0] R128 = 10'h080;
   localparam logic [9:0] R192 = 10'h0c0;
   localparam logic [9:0] R256 = 10'h100;
   localparam logic [9:0] R384 = 10'h180;
   localparam logic [9:0] R512 = 10'h200;
   localparam logic [9:0] CNT_MAX = 10'h3ff;

   // Timing
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned FRAME_LOST_US  = 250;  // Slowest frame, 4 kHz
   localparam int unsigned FRAME_LOST_CYC = FRAME_LOST_US * CLK_MHZ;
   localparam logic [1:0]  SWITCH_GAP     = 2'h3; // Both sources off
endpackage

// File: design/mclk_select.sv
// Master clock source selection, PLL reference and slave clock checks
//
// Behaviour
// R1: Internal master clock comes from PLL or external clock, per switch bits.
// R2: Manual-only mode, or automatic move to external clock on PLL lock loss.
// R3: Every source change is glitch-free: both enables off before the other.
// R4: Reference select 1 locks PLL to aux frame clock, output 256 fs.
// R5: PLL output is 256 fs in single, double and quad speed.
// R6: System keeps external master clock valid while force-lock is 0.
// R7: Master mode clocks from external or PLL; PLL ref receiver or aux frame.
// R8: Slave frame clocks run at sample rate, synchronous to master clock.
// R9: Slave bit clocks are 128, 64, 48 or 32 fs, synchronous to mclk.
// R10: External master clock at least twice fastest slave bit clock.
// R11: Slave port frame clock must be supplied continuously.
// R12: One-line mode one supported in slave mode; mode two refused.
// R13: Slave mclk/frame ratio legal for speed: 256/384/512, 128/192/256, etc.
// R14: Slave bit/frame ratio legal for speed: 32/48/64/128, 32/48/64, etc.
// R15: Speed modes map to oversampling 128x, 64x and 32x.
// R16: Automatic mode returns to PLL only once lock is reported again.
// R17: Lock-loss is synchronised before it steers automatic selection.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
module mclk_select
   import mclk_sel_pkg::*;
#(
   parameter int unsigned FRAME_LOST = FRAME_LOST_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire clk_pins_t   pins,
   output logic             sel_pll_en,
   output logic             sel_ext_en,
   output logic             pll_ref_out,
   output logic [9:0]       pll_mult,
   output logic [1:0][7:0]  osr
);
   typedef enum {S_PLL, S_OFF_TO_EXT, S_EXT, S_OFF_TO_PLL} src_state_t;

   clock_source_switch_ctrl_t ctrl_reg;
   port_mode_t                mode_reg;
   port_mode_t                wr_mode;
   clk_pins_t                 sync1_reg, sync2_reg, sync3_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] rdata_next;
   src_state_t  state_reg;
   logic [1:0]  gap_reg;
   logic        auto_mode, lock_s, want_ext;
   logic [1:0]  frame_s, frame_rise, bclk_rise, slave;
   logic        mclk_rise;
   speed_t      spd [2];
   logic [1:0][9:0] bclk_cnt_reg, mclk_cnt_reg, bclk_ratio_reg, mclk_ratio_reg;
   logic [1:0][15:0] idle_reg;
   logic [1:0]  lost_reg, ratio_ok_reg;

   // Two-stage synchronisers; third stage only for edge finding
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign lock_s    = sync2_reg.pll_lock; // R17
   assign mclk_rise = sync2_reg.ext_master_clock_in
                      & ~sync3_reg.ext_master_clock_in;
   assign frame_s   = {sync2_reg.aux_port_frame_clock,
                       sync2_reg.codec_port_frame_clock};
   assign frame_rise = frame_s & ~{sync3_reg.aux_port_frame_clock,
                                   sync3_reg.codec_port_frame_clock};
   assign bclk_rise = {sync2_reg.aux_port_bit_clock,
                       sync2_reg.codec_port_bit_clock}
                    & ~{sync3_reg.aux_port_bit_clock,
                        sync3_reg.codec_port_bit_clock};
   assign slave = {mode_reg.aux_slave, mode_reg.codec_slave};
   // Write data seen through the port mode layout, so no bit is hand-coded
   assign wr_mode = port_mode_t'(hwdata[$bits(port_mode_t)-1:0]);
   assign spd[0] = mode_reg.codec_speed;
   assign spd[1] = mode_reg.aux_speed;

   // AHB-Lite: zero wait states, always OKAY; writes land in data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata      <= '0;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         wr_pend_reg <= hsel & hready & htrans[1] & hwrite;
         wr_addr_reg <= haddr;
         if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata <= rdata_next;
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_next = '0;
      unique case (haddr)
         CLK_CTRL_OFS:  rdata_next[$bits(ctrl_reg)-1:0] = ctrl_reg;
         PORT_MODE_OFS: rdata_next[$bits(mode_reg)-1:0] = mode_reg;
         STATUS_OFS:    rdata_next[7:0] = {ratio_ok_reg, lost_reg,
                                           sel_ext_en, sel_pll_en,
                                           state_reg == S_EXT, lock_s};
         RATIO_OFS:     rdata_next = {mclk_ratio_reg[1][7:0],
                                      bclk_ratio_reg[1][7:0],
                                      mclk_ratio_reg[0][7:0],
                                      bclk_ratio_reg[0][7:0]};
         default:       rdata_next = '0;
      endcase
   end

   // Register writes; illegal speed code and one-line mode two are refused
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         mode_reg <= MODE_RESET;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == CLK_CTRL_OFS) begin
            ctrl_reg <= hwdata[$bits(ctrl_reg)-1:0]; // R1
         end
         if (wr_addr_reg == PORT_MODE_OFS) begin
            mode_reg.one_line     <= wr_mode.one_line;
            mode_reg.one_line_alt <= 1'b0; // R12
            mode_reg.codec_slave  <= wr_mode.codec_slave;
            mode_reg.aux_slave    <= wr_mode.aux_slave;
            if (wr_mode.codec_speed inside {SPD_SINGLE, SPD_DOUBLE,
                                            SPD_QUAD}) begin
               mode_reg.codec_speed <= wr_mode.codec_speed;
            end
            if (wr_mode.aux_speed inside {SPD_SINGLE, SPD_DOUBLE,
                                          SPD_QUAD}) begin
               mode_reg.aux_speed <= wr_mode.aux_speed;
            end
         end
      end
   end

   // Source decision: manual follows field; auto leaves PLL on lock loss
   assign auto_mode = ctrl_reg.sw[1];
   always_comb begin
      if (auto_mode) begin
         want_ext = !lock_s && !ctrl_reg.force_lock_flag; // R2 R16
      end else begin
         want_ext = (ctrl_reg.sw == SW_MANUAL_EXT);
      end
   end

   // Break-before-make: old enable drops, gap, then new enable rises
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg  <= S_PLL;
         gap_reg    <= '0;
         sel_pll_en <= 1'b1;
         sel_ext_en <= 1'b0;
      end else begin
         unique case (state_reg)
            S_PLL: if (want_ext) begin
               state_reg  <= S_OFF_TO_EXT; // R3
               sel_pll_en <= 1'b0;
               gap_reg    <= '0;
            end
            S_EXT: if (!want_ext) begin
               state_reg  <= S_OFF_TO_PLL; // R3 R16
               sel_ext_en <= 1'b0;
               gap_reg    <= '0;
            end
            S_OFF_TO_EXT, S_OFF_TO_PLL: begin
               gap_reg <= gap_reg + 2'h1;
               if (gap_reg == SWITCH_GAP - 2'h1) begin
                  state_reg  <= (state_reg == S_OFF_TO_EXT) ? S_EXT : S_PLL;
                  sel_ext_en <= (state_reg == S_OFF_TO_EXT);
                  sel_pll_en <= (state_reg == S_OFF_TO_PLL);
               end
            end
         endcase
      end
   end

   // PLL reference and multiple; multiple is fixed in every speed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_ref_out <= 1'b0;
         pll_mult    <= R256;
      end else begin
         pll_ref_out <= ctrl_reg.pll_ref_select; // R4 R7
         pll_mult    <= R256; // R5
      end
   end

   function automatic logic bclk_ok(speed_t s, logic ol, logic [9:0] r);
      if (ol) return r == R128;
      return r == R32 || r == R48 || r == R64 || (s == SPD_SINGLE && r == R128);
   endfunction

   function automatic logic mclk_ok(speed_t s, logic ol, logic [9:0] r);
      logic [9:0] base;
      base = (s == SPD_SINGLE) ? R256 : (s == SPD_DOUBLE) ? R128 : R64;
      if (ol) return r == R256;
      return r == base || r == base + (base >> 1) || r == (base << 1);
   endfunction

   // Per slave port: count bit and master clock edges per frame
   for (genvar i = 0; i < 2; i++) begin : g_port
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            bclk_cnt_reg[i]   <= '0;
            mclk_cnt_reg[i]   <= '0;
            bclk_ratio_reg[i] <= '0;
            mclk_ratio_reg[i] <= '0;
            idle_reg[i]       <= '0;
            lost_reg[i]       <= 1'b0;
            ratio_ok_reg[i]   <= 1'b1;
            osr[i]            <= R128[7:0];
         end else begin
            // Oversampling per speed
            osr[i] <= (spd[i] == SPD_SINGLE) ? R128[7:0] : // R15
                      (spd[i] == SPD_DOUBLE) ? R64[7:0] : R32[7:0];
            if (frame_rise[i]) begin
               bclk_ratio_reg[i] <= bclk_cnt_reg[i];
               mclk_ratio_reg[i] <= mclk_cnt_reg[i];
               bclk_cnt_reg[i]   <= {9'h0, bclk_rise[i]};
               mclk_cnt_reg[i]   <= {9'h0, mclk_rise};
               idle_reg[i]       <= '0;
               lost_reg[i]       <= 1'b0;
            end else begin
               if (bclk_rise[i] && bclk_cnt_reg[i] != CNT_MAX)
                  bclk_cnt_reg[i] <= bclk_cnt_reg[i] + 10'h1;
               if (mclk_rise && mclk_cnt_reg[i] != CNT_MAX)
                  mclk_cnt_reg[i] <= mclk_cnt_reg[i] + 10'h1;
               if (idle_reg[i] != FRAME_LOST[15:0])
                  idle_reg[i] <= idle_reg[i] + 16'h1;
               else
                  lost_reg[i] <= slave[i]; // R11
            end
            // Legal ratios, external clock at least twice bit clock
            ratio_ok_reg[i] <= !slave[i] || (!lost_reg[i]
               && bclk_ok(spd[i], mode_reg.one_line, bclk_ratio_reg[i])
               && mclk_ok(spd[i], mode_reg.one_line, mclk_ratio_reg[i])
               && {1'b0, mclk_ratio_reg[i]}
                  >= {bclk_ratio_reg[i], 1'b0}); // R13 R14 R10
         end
      end
   end

   chk_no_overlap: assert property (@(posedge hclk) // R3
      disable iff (!hresetn) !(sel_pll_en && sel_ext_en))
      else $error("both sources on");
   chk_gap_hold: assert property (@(posedge hclk) // R3
      disable iff (!hresetn) $fell(sel_pll_en) |-> !sel_ext_en [*3])
      else $error("gap short");
   // Eight cycles cover a switch already under way the other way round
   chk_auto_fail: assert property (@(posedge hclk) // R2
      disable iff (!hresetn)
      (auto_mode && !lock_s && !ctrl_reg.force_lock_flag) [*8]
      |-> sel_ext_en) else $error("no failover");
   chk_auto_return: assert property (@(posedge hclk) // R16
      disable iff (!hresetn) (auto_mode && lock_s) [*8] |-> sel_pll_en)
      else $error("no return to pll");
   chk_manual_src: assert property (@(posedge hclk) // R1
      disable iff (!hresetn)
      (ctrl_reg.sw == SW_MANUAL_PLL) [*8] |-> sel_pll_en && !sel_ext_en)
      else $error("manual pll not held");
   chk_lock_sync: assert property (@(posedge hclk) // R17
      disable iff (!hresetn)
      $fell(sel_pll_en) && $past(auto_mode) |-> !$past(sync2_reg.pll_lock))
      else $error("unsynced lock");
   chk_ref_follow: assert property (@(posedge hclk) // R4 R5
      disable iff (!hresetn)
      ##1 pll_ref_out == $past(ctrl_reg.pll_ref_select) && pll_mult == R256)
      else $error("pll ref or mult wrong");
   chk_osr_map: assert property (@(posedge hclk) // R15
      disable iff (!hresetn)
      $stable(spd[0]) && spd[0] == SPD_QUAD |=> osr[0] == R32[7:0])
      else $error("osr map");
   chk_one_line: assert property (@(posedge hclk) // R12
      disable iff (!hresetn) !mode_reg.one_line_alt)
      else $error("one-line two taken");
endmodule

// File: bench/mclk_far_side.sv
// Far-side audio processor model: master, bit and frame clocks
`timescale 1ns/10ps
module mclk_far_side
   import mclk_sel_pkg::*;
#(
   parameter int unsigned BITS_PER_FRAME = 32,
   parameter int unsigned MCLK_HALF_NS   = 40
) (
   input  wire logic lock_ok,
   input  wire logic aux_frame_run,
   output clk_pins_t pins
);
   logic        mclk    = 1'b0;
   logic        bclk    = 1'b0;
   logic        fclk    = 1'b0;
   int unsigned bit_cnt = 0;

   // Master clock never stops, so the block can always fall back on it
   always #(MCLK_HALF_NS) mclk = ~mclk;

   // Bit clock at half the master clock, launched by its rising edge
   always @(posedge mclk) bclk <= ~bclk;

   // Frame clock at the sample rate, derived from the bit clock
   always @(negedge bclk) begin
      if (bit_cnt == BITS_PER_FRAME / 2 - 1) begin
         bit_cnt <= 0;
         fclk    <= ~fclk;
      end else begin
         bit_cnt <= bit_cnt + 1;
      end
   end

   // Aux frame clock stalls only when a scenario asks for a lost frame
   assign pins = {lock_ok, mclk, fclk & aux_frame_run, bclk, fclk, bclk};
endmodule

// File: bench/audio_master_clock_select_tb_top.sv
// Testbench: register access, source switching and slave clock checks
`timescale 1ns/10ps
module audio_master_clock_select_tb_top
   import mclk_sel_pkg::*;
;
   localparam int unsigned LOST = 400;
   logic            hclk;
   logic            hresetn;
   logic            hsel;
   logic            hwrite;
   logic            hready;
   logic            hreadyout;
   logic            hresp;
   logic            sel_pll_en;
   logic            sel_ext_en;
   logic            pll_ref_out;
   logic            lock_ok;
   logic            aux_frame_run;
   logic [1:0]      htrans;
   logic [2:0]      hsize;
   logic [7:0]      haddr;
   logic [31:0]     hwdata;
   logic [31:0]     hrdata;
   logic [31:0]     rd;
   logic [9:0]      pll_mult;
   logic [1:0][7:0] osr;
   clk_pins_t       pins;
   int              error_cnt = 0;
   int              n_checks  = 0;
   int              cycles    = 0;

   assign hready = hreadyout;

   mclk_select #(.FRAME_LOST(LOST)) i_mclk_select (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pins(pins), .sel_pll_en(sel_pll_en),
      .sel_ext_en(sel_ext_en), .pll_ref_out(pll_ref_out),
      .pll_mult(pll_mult), .osr(osr));

   mclk_far_side i_mclk_far_side (
      .lock_ok(lock_ok), .aux_frame_run(aux_frame_run), .pins(pins));

   initial hclk = 1'b0;
   always #10 hclk = ~hclk;

   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard, generous against the few thousand cycles needed
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         $display("MISMATCH %0t timeout", $time);
         complete_run();
      end
   end

   // Both sources on at once would glitch the internal clock
   always @(posedge hclk) begin
      if (hresetn === 1'b1 && sel_pll_en === 1'b1 && sel_ext_en === 1'b1) begin
         error_cnt++;
         $display("MISMATCH %0t both sources enabled", $time);
      end
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Single AHB transfer; waits on hready, no fixed latency assumed
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= a;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] mask);
      bus(1'b0, a, 32'h0);
      check_val(rd & mask, exp, "read");
   endtask

   // Break-before-make: some cycle with neither source must pass
   task automatic wait_en(input logic ext);
      int gap;
      int n;
      gap = 0;
      n = 0;
      while (n < 100 && (ext ? sel_ext_en : sel_pll_en) !== 1'b1) begin
         @(posedge hclk);
         if (sel_pll_en === 1'b0 && sel_ext_en === 1'b0) gap++;
         n++;
      end
      check_val({31'h0, gap > 0}, 32'h1, "gap");
      check_val({30'h0, sel_ext_en, sel_pll_en}, ext ? 32'h2 : 32'h1, "sel");
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 8'h00;
      hwdata = 32'h0;
      lock_ok = 1'b1;
      aux_frame_run = 1'b1;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check_val({30'h0, sel_ext_en, sel_pll_en}, 32'h1, "rst sel");
      check_val({22'h0, pll_mult}, 32'h100, "mult");
      check_val({31'h0, pll_ref_out}, 32'h0, "ref");
      check_val({16'h0, osr}, 32'h8080, "osr");
      rdchk(CLK_CTRL_OFS, 32'h0, 32'hffffffff);
      rdchk(8'h10, 32'h0, 32'hffffffff);
      // Each speed code on both ports
      for (int s = 0; s < 3; s++) begin
         logic [7:0] e;
         e = 8'h80 >> s;
         bus(1'b1, PORT_MODE_OFS, {28'h0, s[1:0], s[1:0]});
         repeat (3) @(posedge hclk);
         check_val({16'h0, osr}, {16'h0, e, e}, "osr");
      end
      // Speed code 3 refused, mode two never sets
      bus(1'b1, PORT_MODE_OFS, 32'hff);
      rdchk(PORT_MODE_OFS, 32'h7a, 32'hffffffff);
      // Slave quad speed: 32 bits and 64 master clocks per frame
      bus(1'b1, PORT_MODE_OFS, 32'h3a);
      repeat (800) @(posedge hclk);
      rdchk(RATIO_OFS, 32'h40204020, 32'hffffffff);
      rdchk(STATUS_OFS, 32'hc5, 32'hffffffff);
      bus(1'b1, PORT_MODE_OFS, 32'h30);
      repeat (700) @(posedge hclk);
      rdchk(STATUS_OFS, 32'h05, 32'hffffffff);
      // Aux frame clock removed in slave mode
      bus(1'b1, PORT_MODE_OFS, 32'h3a);
      aux_frame_run <= 1'b0;
      repeat (LOST + 300) @(posedge hclk);
      rdchk(STATUS_OFS, 32'h20, 32'h30);
      aux_frame_run <= 1'b1;
      // Reference select and manual switching
      bus(1'b1, CLK_CTRL_OFS, 32'h4);
      repeat (3) @(posedge hclk);
      check_val({31'h0, pll_ref_out}, 32'h1, "ref");
      bus(1'b1, CLK_CTRL_OFS, 32'h1);
      wait_en(1'b1);
      bus(1'b1, CLK_CTRL_OFS, 32'h0);
      wait_en(1'b0);
      // Both automatic codes fail over and come back with lock
      for (int c = 2; c < 4; c++) begin
         bus(1'b1, CLK_CTRL_OFS, {30'h0, c[1:0]});
         lock_ok <= 1'b0;
         wait_en(1'b1);
         lock_ok <= 1'b1;
         wait_en(1'b0);
      end
      // Force-lock holds the PLL source despite lock loss
      bus(1'b1, CLK_CTRL_OFS, 32'ha);
      lock_ok <= 1'b0;
      repeat (20) @(posedge hclk);
      check_val({30'h0, sel_ext_en, sel_pll_en}, 32'h1, "force");
      lock_ok <= 1'b1;
      complete_run();
   end
endmodule
